// >>> core/blink_divider.sv
// shared blink phase generator
`timescale 1ns/1ps
`include "panel_defines.svh"
module blink_divider
(
    input wire logic clk,
    input wire logic rst_n,
    output logic phase
);
    logic [`DIV_W-1:0] count;
    wire last = (count == `DIV_W'(`HALF_PERIOD - 1));
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            phase <= 1'b0;
        end
        else
        begin
            count <= last ? '0 : count + 1'b1; // see RULE1
            if (last)
                phase <= ~phase; // see RULE16
        end
    end
endmodule

// >>> core/front_panel_lights.sv
// front panel indicator encoder
`timescale 1ns/1ps
`include "panel_defines.svh"
module front_panel_lights
    import panel_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic acpi_mode,
    input wire logic sys_power_on,
    input wire logic [2:0] sleep_state,
    input wire logic standby_sleep_held,
    input wire logic fw_sleep_clear,
    input wire logic fault_critical,
    input wire logic fault_noncritical,
    input wire logic degraded,
    input wire logic self_test,
    input wire logic disk_pulse,
    input wire logic ident_button_n,
    input wire logic ident_request,
    input wire logic ident_cancel,
    input wire logic [1:0] net_link,
    input wire logic [1:0] net_activity,
    output logic power_light_n,
    output logic status_light_a_n,
    output logic status_light_b_n,
    output logic disk_activity_light_n,
    output logic ident_light_n,
    output logic sleep_hold,
    output logic net0_link_light_n,
    output logic net0_activity_light_n,
    output logic net1_link_light_n,
    output logic net1_activity_light_n
);
    // ************************************************
    // blink phase
    // ************************************************
    logic phase;
    blink_divider u_div
    (
        .clk(clk),
        .rst_n(rst_n),
        .phase(phase)
    );

    // ************************************************
    // power state decode
    // ************************************************
    power_mode_e mode;
    wire sleeping = (sleep_state >= 3'h1) && (sleep_state <= 3'h3);
    always_comb
    begin
        if (!acpi_mode)
            mode = sys_power_on ? PWR_LEG_ON : PWR_LEG_OFF; // see RULE8
        else if (!sys_power_on || sleep_state >= 3'h4)
            mode = PWR_SOFT; // see RULE6
        else if (sleeping)
            mode = PWR_SLEEP; // see RULE7
        else
            mode = PWR_S0; // see RULE5
    end

    // sleep indication kept in the standby domain; a stale one survives an
    // abnormal power-off until firmware clears it
    logic sleep_flag;
    logic loaded;
    wire next_sleep_flag = (mode == PWR_SLEEP) ? 1'b1 :
        fw_sleep_clear ? 1'b0 : sleep_flag; // see RULE10

    logic power_on;
    always_comb
    begin
        case (mode)
            PWR_S0: power_on = sleep_flag ? phase : 1'b1;
            PWR_LEG_ON: power_on = sleep_flag ? phase : 1'b1;
            PWR_SLEEP: power_on = phase; // see RULE7
            PWR_SOFT: power_on = 1'b0;
            PWR_LEG_OFF: power_on = 1'b0; // see RULE9
            default: power_on = 1'b0;
        endcase
    end

    // ************************************************
    // status, disk, identification
    // ************************************************
    wire amber = fault_critical ? 1'b1 :
        fault_noncritical ? phase : 1'b0; // see RULE3
    wire amber_active = fault_critical | fault_noncritical;
    wire green = (amber_active || self_test) ? 1'b0 :
        degraded ? phase : 1'b1; // see RULE2 see RULE4

    // stretch each pulse so that bursts appear as irregular flicker
    logic [19:0] disk_hold;
    wire disk_allowed = sys_power_on && !(acpi_mode && sleep_state != 3'h0);
    wire [19:0] next_disk_hold = (disk_pulse && disk_allowed) ? `DISK_HOLD :
        (disk_hold != 20'h00000) ? disk_hold - 20'h00001 : 20'h00000;

    logic ident_active;
    logic button_prev;
    wire press = !ident_button_n && button_prev;
    wire next_ident = (press || ident_request) ? 1'b1 :
        ident_cancel ? 1'b0 : ident_active; // see RULE13

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleep_flag <= 1'b0;
            loaded <= 1'b0;
            disk_hold <= 20'h00000;
            ident_active <= 1'b0;
            button_prev <= 1'b1;
        end
        else
        begin
            loaded <= 1'b1;
            sleep_flag <= loaded ? next_sleep_flag : standby_sleep_held;
            disk_hold <= disk_allowed ? next_disk_hold : 20'h00000;
            ident_active <= next_ident;
            button_prev <= ident_button_n;
        end
    end

    // ************************************************
    // output flops, active low; reset darkens all
    // ************************************************
    // one helper so the identification and network activity lights take the same shared phase
    function automatic logic blink_of(input logic enable, input logic ph);
        return enable & ph;
    endfunction

    wire ident_on = blink_of(ident_active, phase); // see RULE12
    wire disk_on = (disk_hold != 20'h00000); // see RULE11

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            power_light_n <= 1'b1; // see RULE16
            status_light_a_n <= 1'b1;
            status_light_b_n <= 1'b1;
        end
        else
        begin
            power_light_n <= ~power_on;
            status_light_a_n <= ~green;
            status_light_b_n <= ~amber;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            disk_activity_light_n <= 1'b1;
            ident_light_n <= 1'b1;
        end
        else
        begin
            disk_activity_light_n <= ~disk_on;
            ident_light_n <= ~ident_on;
        end
    end

    // the write-back follows the value just loaded, but at the loading edge the standby
    // store still takes the reset 0 of sleep_hold and keeps it for one cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sleep_hold <= 1'b0;
        else
            sleep_hold <= loaded ? next_sleep_flag : standby_sleep_held;
    end

    // ************************************************
    // network lights
    // ************************************************
    logic [1:0] link_dark;
    logic [1:0] act_dark;
    genvar n;
    generate
        for (n = 0; n < 2; n++)
        begin : g_net
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    link_dark[n] <= 1'b1;
                    act_dark[n] <= 1'b1;
                end
                else
                begin
                    link_dark[n] <= ~net_link[n]; // see RULE15
                    act_dark[n] <= ~blink_of(net_activity[n], phase);
                end
            end
        end
    endgenerate

    assign net0_link_light_n = link_dark[0];
    assign net0_activity_light_n = act_dark[0];
    assign net1_link_light_n = link_dark[1];
    assign net1_activity_light_n = act_dark[1];
endmodule

// >>> core/panel_defines.svh
// constants and overview for the front panel indicator logic
//
// Overview of operation
// RULE1: blinking lights toggle near one hertz, half on, half off
// RULE2: amber status lit or blinking forces the green status element off
// RULE3: critical gives steady amber, non-critical only gives blinking amber
// RULE4: no amber: normal steady green, degraded blinks green, self-test dark
// RULE5: power light steady on in S0 or legacy powered-on state, blinking instead while a sleep indication is held
// RULE6: power light dark in S4, S5 or with power off
// RULE7: power light blinks while DC stays on in sleep S1 to S3
// RULE8: non-ACPI: power light lit once system power is on
// RULE9: non-ACPI: power light dark while power off, chipset uninitialised
// RULE10: sleep indication held on standby, restored, kept until firmware clears
// RULE11: disk light follows activity pulses, dark when off or in S1
// RULE12: identification light blinks while identify is active, else dark
// RULE13: button press or remote request activates identification
// RULE14: controller reports degraded for lost redundancy only if redundant
// RULE15: network light steady on link, blinking on activity
// RULE16: all blinks share one divider; reset darkens every light
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH
`define CLK_HZ 10000000
`define BLINK_HZ 1
// cycles per half blink period
`define HALF_PERIOD (`CLK_HZ / (2 * `BLINK_HZ))
`define DIV_W 23
`define DISK_HOLD 20'h186A0
`endif

// >>> core/panel_pkg.sv
// types for the front panel indicator logic
package panel_pkg;
    typedef enum logic [5:0] {
        PWR_OFF    = 6'h01,
        PWR_S0     = 6'h02,
        PWR_SLEEP  = 6'h04,
        PWR_SOFT   = 6'h08,
        PWR_LEG_ON = 6'h10,
        PWR_LEG_OFF = 6'h20
    } power_mode_e;
endpackage

// >>> verif/front_panel_asserts.sv
// concurrent checks on the front panel indicator ports
`timescale 1ns/1ps
module front_panel_asserts
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic acpi_mode,
    input wire logic sys_power_on,
    input wire logic [2:0] sleep_state,
    input wire logic fault_critical,
    input wire logic fault_noncritical,
    input wire logic self_test,
    input wire logic [1:0] net_link,
    input wire logic power_light_n,
    input wire logic status_light_a_n,
    input wire logic status_light_b_n,
    input wire logic disk_activity_light_n,
    input wire logic net0_link_light_n,
    input wire logic net1_link_light_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_amber_over_green: assert property (!status_light_b_n |->
        status_light_a_n) else $error("green lit beside amber");
    a_crit_amber_on: assert property (fault_critical |=>
        !status_light_b_n) else $error("amber not steady");
    a_noncrit_green_off: assert property (fault_noncritical |=>
        status_light_a_n) else $error("green lit on fault");
    a_self_test_dark: assert property (self_test &&
        !fault_critical && !fault_noncritical |=>
        status_light_a_n && status_light_b_n)
        else $error("status lit in self-test");
    a_power_off_dark: assert property (!sys_power_on ||
        acpi_mode && sleep_state > 3'h3 |=> power_light_n)
        else $error("power lit");
    a_disk_off_dark: assert property (!sys_power_on [*2] |=>
        disk_activity_light_n) else $error("disk lit when off");
    a_net0_link_on: assert property (net_link[0] |=>
        !net0_link_light_n) else $error("link light dark");
    a_net1_link_off: assert property (!net_link[1] |=>
        net1_link_light_n) else $error("link light lit");
    cover property (!status_light_b_n);
    cover property (!disk_activity_light_n);
    cover property (!power_light_n);
endmodule
bind front_panel_lights front_panel_asserts chk (.*);

// >>> verif/front_panel_lights_tb.sv
// self-checking bench for the front panel indicator logic
`timescale 1ns/1ps
module front_panel_lights_tb;
    logic clk = 1'b0, rst_n = 1'b0, acpi_mode = 1'b1, sys_power_on = 1'b0;
    logic fw_sleep_clear = 1'b0, fault_critical = 1'b0, self_test = 1'b0;
    logic fault_noncritical = 1'b0, disk_pulse = 1'b0, press = 1'b0;
    logic ident_request = 1'b0, ident_cancel = 1'b0, supply_lost = 1'b0;
    logic redundant_cfg = 1'b0, degraded, ident_button_n, sleep_hold;
    logic [2:0] sleep_state = 3'h0;
    logic [1:0] net_link = 2'h0, net_activity = 2'h0;
    logic standby_sleep_held, power_light_n, status_light_a_n;
    logic status_light_b_n, disk_activity_light_n, ident_light_n;
    logic net0_link_light_n, net0_activity_light_n, net1_link_light_n;
    logic net1_activity_light_n;
    logic [4:0] pw[5] = '{5'h00, 5'h08, 5'h18, 5'h1C, 5'h1D};
    int failures = 0, check_count = 0, cycles = 0;
    front_panel_lights DUT (.*);
    panel_partner partner (.*);
    initial forever #50 clk = ~clk;
    task automatic check(logic got, logic exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t light mismatch", $time);
        end
    endtask
    task automatic wrap_up();
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic pw_dark(logic [4:0] v);
        return !(v[3] && (!v[4] || v[2:0] == 3'h0));
    endfunction
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            wrap_up();
        end
    end
    initial
    begin
        void'($urandom(32'hb08f4b45));
        tick(4);
        rst_n <= 1'b1;
        tick(1);
        repeat (40)
        begin
            {fault_critical, fault_noncritical, self_test, redundant_cfg,
                supply_lost, press, ident_request, ident_cancel} <= $urandom;
            {net_link, net_activity} <= $urandom;
            tick(3);
            check(status_light_b_n, !fault_critical);
            check(status_light_a_n, fault_critical | fault_noncritical |
                self_test | degraded);
            check(net0_link_light_n, !net_link[0]);
            check(net1_link_light_n, !net_link[1]);
            check(net0_activity_light_n & ident_light_n, 1'b1);
        end
        foreach (pw[i])
        begin
            {acpi_mode, sys_power_on, sleep_state} <= pw[i];
            tick(3);
            check(power_light_n, pw_dark(pw[i]));
        end
        {acpi_mode, sys_power_on, sleep_state} <= 5'h19;
        disk_pulse <= 1'b1;
        tick(1);
        disk_pulse <= 1'b0;
        tick(3);
        check(disk_activity_light_n, 1'b1);
        check(power_light_n & sleep_hold, 1'b1);
        rst_n <= 1'b0;
        sleep_state <= 3'h0;
        tick(4);
        check(&{power_light_n, status_light_b_n,
            disk_activity_light_n}, 1'b1);
        rst_n <= 1'b1;
        tick(4);
        check(power_light_n & sleep_hold, 1'b1);
        fw_sleep_clear <= 1'b1;
        tick(1);
        fw_sleep_clear <= 1'b0;
        tick(3);
        check(power_light_n, 1'b0);
        disk_pulse <= 1'b1;
        tick(1);
        disk_pulse <= 1'b0;
        tick(2);
        check(disk_activity_light_n, 1'b0);
        sys_power_on <= 1'b0;
        tick(3);
        check(disk_activity_light_n & power_light_n, 1'b1);
        wrap_up();
    end
endmodule

// >>> verif/panel_partner.sv
// management controller and standby storage model
`timescale 1ns/1ps
module panel_partner
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic redundant_cfg,
    input wire logic supply_lost,
    input wire logic press,
    input wire logic sleep_hold,
    output logic degraded,
    output logic ident_button_n,
    output logic standby_sleep_held
);
    initial {degraded, ident_button_n, standby_sleep_held} = 3'h2;
    // storage sits on standby power, so main reset never wipes it
    always @(posedge clk)
    begin
        degraded <= redundant_cfg & supply_lost;
        ident_button_n <= !press;
        // main power down: the block's write-back is not valid, keep the store
        if (rst_n)
            standby_sleep_held <= sleep_hold;
    end
endmodule
